// >>> design/ppcd_top.sv
// controller command register decoder and executor
//
// Function
// - upper nibble selects type, lower holds parameters
// - register reads zero once command executes
// - reconfigure disables transfers until parallel enable
// - reconfigure plus bit zero resets whole chip
// - soft reset clears revision, reloads after init
// - parallel: bit6 set, bit7 clear, bits2-0
// - parallel order: disable, flush, then enable
// - bit two disables transfers, pin inactive
// - bit one flushes FIFO in any state
// - bit zero enables transfers, pin active
// - signal command overrides busy and ack pins
// - controller mode ignores ack pulse request
// - output modes keep busy requests off pin
// - signal order: set busy, ack, clear busy; the ack pin falls one cycle after busy clears
// - signal bits: set busy, ack, clear busy
// - ack pulse lasts programmed acknowledge width, four units at least
// - timer flag bit four, enable bit three
// - timer may share write with parallel, signal
// - parallel wins when signal also set
// - upper nibble 1001 to 1111 does nothing
// - mode and direction pins change on reconfigure
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module ppcd_top
  import ppcd_pkg::*;
#(
  parameter int         UNIT_CYC = ACK_UNIT_CYC, // cycles per ack width unit
  parameter int         INIT_CYC = INIT_CYCLES,  // reset initialisation time
  parameter logic [7:0] REV_CODE = 8'h5A         // arbitrary revision value
) (
  input  wire logic       mclk,              // system clock
  input  wire logic       reset,             // sync reset, high
  input  wire logic       ce,                // clock enable
  input  wire logic [7:0] reg_addr,          // register address
  input  wire logic [7:0] reg_wdata,         // write data
  input  wire logic       reg_wr,            // write strobe
  input  wire logic       reg_rd,            // read strobe
  output var  logic [7:0] reg_rdata_q,       // read data, next cycle
  output var  logic       transfers_enabled, // channel enabled pin
  output var  logic       fifo_flush,        // one-cycle flush pulse
  output var  logic       timer_enable,      // timer run enable
  output var  logic       mode_pin,          // applied mode bit
  output var  logic       dir_pin,           // applied direction bit
  output var  logic       busy_out,          // busy pin level
  output var  logic       busy_oe_n,         // busy drive enable, low
  output var  logic       ack_n_out,         // ack pin level, low
  output var  logic       ack_oe_n           // ack drive enable, low
);

  // ****************************************************************
  // state
  // ****************************************************************
  ppcd_state_e state_q;
  logic [7:0]  cmd_q;
  logic [7:0]  gcfg_q;
  logic [7:0]  ack_width_q;
  logic [7:0]  revision_q;
  logic        soft_rst_q;
  logic        ack_start_q;
  logic        ack_active;
  logic        init_done;
  logic        srst;
  logic        cgc_go;
  logic        par_go;
  logic        sig_go;
  logic [7:0]  rd_mux;

  generate
    if (REV_CODE == 8'h00) begin : g_bad_rev
      $error("revision code must be nonzero");
    end
  endgenerate

  // hard pin and soft command share one reset path
  assign srst = reset | soft_rst_q;

  // decoded types of the pending command
  assign cgc_go = is_cgc(cmd_q);
  assign par_go = is_par(cmd_q);
  assign sig_go = is_sig(cmd_q) && !par_go;

  // ****************************************************************
  // helpers
  // ****************************************************************
  ppcd_init_seq #(
    .CYCLES (INIT_CYC)
  ) u_init (
    .mclk   (mclk),
    .reset  (srst),
    .ce     (ce),
    .done_q (init_done)
  );

  ppcd_ack_pulse #(
    .UNIT_CYC (UNIT_CYC)
  ) u_ack (
    .mclk     (mclk),
    .reset    (srst),
    .ce       (ce),
    .start    (ack_start_q),
    .width    (ack_width_q),
    .active_q (ack_active)
  );

  // ****************************************************************
  // register writes
  // ****************************************************************
  // writes are dropped while init runs; host waits for revision
  always_ff @(posedge mclk) begin
    if (srst) begin
      gcfg_q      <= GCFG_RST;
      ack_width_q <= ACK_WIDTH_RST;
    end else if (ce && reg_wr && init_done) begin
      if (reg_addr == ADDR_GCFG) begin
        gcfg_q <= reg_wdata & GCFG_MASK;
      end
      if (reg_addr == ADDR_ACK_WIDTH) begin
        ack_width_q <= reg_wdata;
      end
    end
  end

  // command register: taken only when idle and clear
  always_ff @(posedge mclk) begin
    if (srst) begin
      cmd_q <= CMD_IDLE;
    end else if (ce) begin
      if (state_q == ST_DONE) begin
        cmd_q <= CMD_IDLE;
      end else if (reg_wr && init_done && reg_addr == ADDR_CMD &&
                   state_q == ST_IDLE && cmd_q == CMD_IDLE) begin
        cmd_q <= reg_wdata;
      end
    end
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  // three steps give the documented ordering of parameters
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= ST_IDLE;
    end else if (ce) begin
      unique case (state_q)
        ST_IDLE: begin
          if (cmd_q != CMD_IDLE) begin
            state_q <= ST_STEP1;
          end
        end
        ST_STEP1: state_q <= ST_STEP2;
        ST_STEP2: state_q <= ST_STEP3;
        ST_STEP3: state_q <= ST_DONE;
        ST_DONE:  state_q <= ST_IDLE;
        default:  state_q <= ST_IDLE;
      endcase
    end
  end

  // soft reset pulse, reset only by the pin
  always_ff @(posedge mclk) begin
    if (reset) begin
      soft_rst_q <= 1'b0;
    end else if (ce) begin
      soft_rst_q <= (state_q == ST_STEP1) && cgc_go && cmd_q[CMD_RST_BIT];
    end
  end

  // ****************************************************************
  // parallel channel
  // ****************************************************************
  // disable in step one, enable in step three, so both can apply
  always_ff @(posedge mclk) begin
    if (srst) begin
      transfers_enabled <= 1'b0;
    end else if (ce) begin
      if (state_q == ST_STEP1 && cgc_go) begin
        transfers_enabled <= 1'b0;
      end else if (state_q == ST_STEP1 && par_go && cmd_q[PAR_DISABLE]) begin
        transfers_enabled <= 1'b0;
      end else if (state_q == ST_STEP3 && par_go && cmd_q[PAR_ENABLE]) begin
        transfers_enabled <= 1'b1;
      end
    end
  end

  // flush does not look at the enable state
  always_ff @(posedge mclk) begin
    if (srst) begin
      fifo_flush <= 1'b0;
    end else if (ce) begin
      fifo_flush <= (state_q == ST_STEP2) && par_go && cmd_q[PAR_FLUSH];
    end
  end

  // ****************************************************************
  // timer and configuration pins
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      timer_enable <= 1'b0;
    end else if (ce && state_q == ST_STEP1 && is_tim(cmd_q)) begin
      timer_enable <= cmd_q[CMD_TIM_EN];
    end
  end

  // pins follow the config register only on reconfigure
  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_pin <= GCFG_RST[GCFG_MODE];
      dir_pin  <= GCFG_RST[GCFG_DIR];
    end else if (ce && state_q == ST_STEP1 && cgc_go) begin
      mode_pin <= gcfg_q[GCFG_MODE];
      dir_pin  <= gcfg_q[GCFG_DIR];
    end
  end

  // ****************************************************************
  // handshake overrides
  // ****************************************************************
  // busy changes only in input modes; elsewhere the pin is an input
  always_ff @(posedge mclk) begin
    if (srst) begin
      busy_out <= 1'b0;
    end else if (ce && sig_go && dir_pin) begin
      if (state_q == ST_STEP1 && cmd_q[SIG_SET_BUSY]) begin
        busy_out <= 1'b1;
      end else if (state_q == ST_STEP3 && cmd_q[SIG_CLR_BUSY]) begin
        busy_out <= 1'b0;
      end
    end
  end

  // ack request only counts in peripheral modes
  always_ff @(posedge mclk) begin
    if (srst) begin
      ack_start_q <= 1'b0;
    end else if (ce) begin
      ack_start_q <= (state_q == ST_STEP2) && sig_go && cmd_q[SIG_ACK] && mode_pin;
    end
  end

  // pin drivers, registered so outputs come from flops
  always_ff @(posedge mclk) begin
    if (srst) begin
      ack_n_out <= 1'b1;
      ack_oe_n  <= 1'b1;
      busy_oe_n <= 1'b1;
    end else if (ce) begin
      ack_n_out <= !(ack_active && mode_pin);
      ack_oe_n  <= !mode_pin;
      busy_oe_n <= !dir_pin;
    end
  end

  // ****************************************************************
  // revision register
  // ****************************************************************
  // reads zero until init completes, a cue for host software
  always_ff @(posedge mclk) begin
    if (srst) begin
      revision_q <= 8'h00;
    end else if (ce) begin
      revision_q <= init_done ? REV_CODE : 8'h00;
    end
  end

  // ****************************************************************
  // register reads
  // ****************************************************************
  always_comb begin
    unique case (reg_addr)
      ADDR_GCFG:      rd_mux = gcfg_q;
      ADDR_ACK_WIDTH: rd_mux = ack_width_q;
      ADDR_CMD:       rd_mux = cmd_q;
      ADDR_REVISION:  rd_mux = revision_q;
      default:        rd_mux = READ_ZERO;
    endcase
  end

  // data stand one cycle only, zero otherwise
  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_rdata_q <= READ_ZERO;
    end else if (ce) begin
      reg_rdata_q <= reg_rd ? rd_mux : READ_ZERO;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  a_cmd_self_clear: assert property (
    (state_q == ST_DONE && ce) |=> cmd_q == CMD_IDLE)
    else $error("command register not cleared");

  a_cgc_disables: assert property (
    (state_q == ST_STEP1 && ce && cgc_go) |=> !transfers_enabled)
    else $error("reconfigure left transfers on");

  a_cgc_pins_load: assert property (
    (state_q == ST_STEP1 && ce && cgc_go && !cmd_q[CMD_RST_BIT])
    |=> mode_pin == $past(gcfg_q[GCFG_MODE]) && dir_pin == $past(gcfg_q[GCFG_DIR]))
    else $error("mode pins not loaded");

  a_par_disable: assert property (
    (state_q == ST_STEP1 && ce && par_go && cmd_q[PAR_DISABLE])
    |=> !transfers_enabled)
    else $error("disable did not act");

  a_par_enable: assert property (
    (state_q == ST_STEP3 && ce && par_go && cmd_q[PAR_ENABLE])
    |=> transfers_enabled)
    else $error("enable did not act");

  a_flush_cause: assert property (
    fifo_flush |-> state_q == ST_STEP3 && par_go && cmd_q[PAR_FLUSH])
    else $error("stray flush pulse");

  a_bad_nibble: assert property (
    (state_q == ST_STEP1 && ce && cmd_q[7:4] > 4'h8)
    |=> $stable(transfers_enabled) && $stable(busy_out) && $stable(timer_enable))
    else $error("reserved nibble had effect");

  a_sig_masked: assert property (
    (state_q == ST_STEP1 && ce && par_go && !is_tim(cmd_q)) |=> $stable(busy_out))
    else $error("signal ran beside parallel");

  a_ack_peripheral: assert property (
    !ack_n_out |-> $past(mode_pin))
    else $error("ack driven in controller mode");

  a_busy_input_mode: assert property (
    $rose(busy_out) |-> $past(dir_pin))
    else $error("busy set in output mode");

  c_par_all: cover property (
    state_q == ST_STEP1 && par_go && cmd_q[2:0] == 3'h7);
  c_ack_pulse: cover property ($fell(ack_n_out));
  c_busy_pulse: cover property ($rose(busy_out) ##[1:4] $fell(busy_out));
  c_soft_reset: cover property (soft_rst_q);

endmodule : ppcd_top
`default_nettype wire

// >>> shared/ppcd_pkg.sv
// constants, states and decode helpers for the command decoder
package ppcd_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_ACK_WIDTH = 8'h03;
  localparam logic [7:0] ADDR_GCFG      = 8'h0A;
  localparam logic [7:0] ADDR_CMD       = 8'h0B;
  localparam logic [7:0] ADDR_REVISION  = 8'h0F;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int CMD_CGC_BIT  = 7;
  localparam int CMD_TIM_EN   = 3;
  localparam int CMD_RST_BIT  = 0;
  localparam int PAR_DISABLE  = 2;
  localparam int PAR_FLUSH    = 1;
  localparam int PAR_ENABLE   = 0;
  localparam int SIG_SET_BUSY = 2;
  localparam int SIG_ACK      = 1;
  localparam int SIG_CLR_BUSY = 0;
  localparam int GCFG_DIR     = 0;
  localparam int GCFG_MODE    = 1;

  localparam logic [7:0] GCFG_MASK     = 8'h07;
  localparam logic [7:0] GCFG_RST      = 8'h00;
  localparam logic [7:0] CMD_IDLE      = 8'h00;
  localparam logic [7:0] ACK_WIDTH_RST = 8'h05;
  localparam logic [7:0] ACK_WIDTH_MIN = 8'h04;
  localparam logic [7:0] READ_ZERO     = 8'h00;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int ACK_UNIT_NS   = 200;
  localparam int ACK_UNIT_CYC  = (ACK_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_TIME_NS  = 1000;
  localparam int INIT_CYCLES   = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // sequencer states
  // ****************************************************************
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_STEP1 = 5'h02,
    ST_STEP2 = 5'h04,
    ST_STEP3 = 5'h08,
    ST_DONE  = 5'h10
  } ppcd_state_e;

  // ****************************************************************
  // command type decode from the upper nibble
  // ****************************************************************
  function automatic logic is_cgc(input logic [7:0] cmd);
    return cmd[7:4] == 4'h8;
  endfunction : is_cgc

  function automatic logic is_par(input logic [7:0] cmd);
    return cmd[7:6] == 2'h1;
  endfunction : is_par

  function automatic logic is_sig(input logic [7:0] cmd);
    return cmd[7:5] == 3'h1;
  endfunction : is_sig

  function automatic logic is_tim(input logic [7:0] cmd);
    return cmd[7:4] inside {4'h1, 4'h3, 4'h5, 4'h7};
  endfunction : is_tim

endpackage : ppcd_pkg

// >>> design/ppcd_init_seq.sv
// initialisation timer that reports when reset work is complete
`timescale 1ns/10ps
`default_nettype none
module ppcd_init_seq
  import ppcd_pkg::*;
#(
  parameter int CYCLES = INIT_CYCLES
) (
  input  wire logic mclk,   // system clock
  input  wire logic reset,  // hard or soft reset, sync high
  input  wire logic ce,     // clock enable
  output var  logic done_q  // init finished
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt_q;

  generate
    if (CYCLES < 1) begin : g_bad
      $error("init cycles must be at least one");
    end
  endgenerate

  // ****************************************************************
  // count down after every reset
  // ****************************************************************
  // restarts on any reset so a soft reset looks like power-on
  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt_q  <= CW'(CYCLES);
      done_q <= 1'b0;
    end else if (ce) begin
      if (cnt_q != '0) begin
        cnt_q <= cnt_q - 1'b1;
      end
      done_q <= (cnt_q == CW'(1)) || done_q;
    end
  end

endmodule : ppcd_init_seq
`default_nettype wire

// >>> design/ppcd_ack_pulse.sv
// acknowledge pulse timer measured in width units
`timescale 1ns/10ps
`default_nettype none
module ppcd_ack_pulse
  import ppcd_pkg::*;
#(
  parameter int UNIT_CYC = ACK_UNIT_CYC
) (
  input  wire logic       mclk,     // system clock
  input  wire logic       reset,    // sync high
  input  wire logic       ce,       // clock enable
  input  wire logic       start,    // one-cycle request
  input  wire logic [7:0] width,    // units per pulse
  output var  logic       active_q  // pulse in progress
);

  localparam int UW = $clog2(UNIT_CYC + 1);

  logic [UW-1:0] unit_q;
  logic [7:0]    left_q;

  generate
    if (UNIT_CYC < 1) begin : g_bad
      $error("ack unit must be at least one cycle");
    end
  endgenerate

  // ****************************************************************
  // unit prescaler and unit countdown
  // ****************************************************************
  // widths below the minimum are raised so a pulse is never too short
  always_ff @(posedge mclk) begin
    if (reset) begin
      active_q <= 1'b0;
      unit_q   <= '0;
      left_q   <= '0;
    end else if (ce) begin
      if (start && !active_q) begin
        active_q <= 1'b1;
        unit_q   <= UW'(UNIT_CYC - 1);
        left_q   <= (width < ACK_WIDTH_MIN) ? ACK_WIDTH_MIN : width;
      end else if (active_q) begin
        if (unit_q != '0) begin
          unit_q <= unit_q - 1'b1;
        end else begin
          unit_q   <= UW'(UNIT_CYC - 1);
          left_q   <= left_q - 1'b1;
          active_q <= (left_q != 8'h01);
        end
      end
    end
  end

endmodule : ppcd_ack_pulse
`default_nettype wire

// >>> verification/ppcd_host_model.sv
// host processor model driving the decoder register port
`timescale 1ns/10ps
`default_nettype none
module ppcd_host_model
  import ppcd_pkg::*;
(
  input  wire logic       mclk,        // system clock
  output var  logic [7:0] reg_addr,    // register address
  output var  logic [7:0] reg_wdata,   // write data
  output var  logic       reg_wr,      // write strobe
  output var  logic       reg_rd,      // read strobe
  input  wire logic [7:0] reg_rdata_q  // read data
);
  // ****************************************************************
  // bus cycles
  // ****************************************************************
  // quiet bus from time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // released data is inverted so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr

  // data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata_q;
  endtask : rd

  // bounded polls of one register for an expected value
  task automatic poll(input logic [7:0] a, input logic [7:0] v, output bit ok);
    logic [7:0] d;
    ok = 1'b0;
    for (int i = 0; i < 60 && !ok; i++) begin
      rd(a, d);
      ok = (d === v);
    end
  endtask : poll

  // next command only after the register reads back cleared
  task automatic cmd(input logic [7:0] c, output bit ok);
    wr(ADDR_CMD, c);
    poll(ADDR_CMD, CMD_IDLE, ok);
  endtask : cmd
endmodule : ppcd_host_model
`default_nettype wire

// >>> verification/ppcd_tb_top.sv
// self-checking bench for the command decoder
`timescale 1ns/10ps
`default_nettype none
module ppcd_tb_top
  import ppcd_pkg::*;
;
  localparam int         UNIT    = 2;
  localparam int         INIT    = 4;
  localparam logic [7:0] REV     = 8'hA5;  // arbitrary value
  localparam logic [7:0] ACK_LOW = 8'(ACK_WIDTH_RST * UNIT);

  logic       mclk;
  logic       reset;
  logic       ce;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata_q;
  logic       transfers_enabled;
  logic       fifo_flush;
  logic       timer_enable;
  logic       mode_pin;
  logic       dir_pin;
  logic       busy_out;
  logic       busy_oe_n;
  logic       ack_n_out;
  logic       ack_oe_n;
  logic       fl_seen;
  logic       bz_seen;
  logic [7:0] ak_cnt;
  logic [7:0] d;
  logic [7:0] outs;
  logic [7:0] flags;
  bit         ok;
  int         err_total;
  int         num_checks;

  // row: command, then enabled, timer, flush seen, busy expected
  logic [11:0] rows [14] = '{12'h418, 12'h440, 12'h43A, 12'h47A, 12'h58C, 12'h08C, 12'h108,
                             12'h968, 12'hC48, 12'h662, 12'h3D4, 12'h7DC, 12'h804, 12'h0F4};

  assign outs  = {transfers_enabled, timer_enable, mode_pin, dir_pin,
                  busy_out, busy_oe_n, ack_oe_n, ack_n_out};
  assign flags = {4'h0, transfers_enabled, timer_enable, fl_seen, busy_out};

  // ****************************************************************
  // clock, design and host
  // ****************************************************************
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  ppcd_top #(.UNIT_CYC(UNIT), .INIT_CYC(INIT), .REV_CODE(REV)) DUT (
    .mclk(mclk), .reset(reset), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .transfers_enabled(transfers_enabled),
    .fifo_flush(fifo_flush), .timer_enable(timer_enable), .mode_pin(mode_pin),
    .dir_pin(dir_pin), .busy_out(busy_out), .busy_oe_n(busy_oe_n),
    .ack_n_out(ack_n_out), .ack_oe_n(ack_oe_n));

  ppcd_host_model HOST (
    .mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));

  // pulses are short, so they are caught here rather than by polling
  always @(posedge mclk) begin
    if (fifo_flush === 1'b1) fl_seen <= 1'b1;
    if (busy_out === 1'b1) bz_seen <= 1'b1;
    if (ack_n_out === 1'b0) ak_cnt <= ak_cnt + 8'h01;
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // off the edge, so no race with the monitor above
  task automatic clr;
    #2;
    fl_seen = 1'b0;
    bz_seen = 1'b0;
    ak_cnt  = 8'h00;
  endtask : clr

  task automatic go(input logic [7:0] c);
    HOST.cmd(c, ok);
    chk({7'h00, ok}, 8'h01);
    if (!ok) summarize();
  endtask : go

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    reset = 1'b1;
    ce    = 1'b1;
    clr();
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    #1 chk(outs, 8'h07);
    HOST.rd(ADDR_REVISION, d);
    chk(d, 8'h00);
    HOST.poll(ADDR_REVISION, REV, ok);
    chk({7'h00, ok}, 8'h01);
    if (!ok) summarize();
    HOST.rd(ADDR_ACK_WIDTH, d);
    chk(d, ACK_WIDTH_RST);
    HOST.wr(ADDR_REVISION, 8'h00);
    HOST.rd(ADDR_REVISION, d);
    chk(d, REV);
    HOST.rd(8'h01, d);
    chk(d, READ_ZERO);
    $display("test done: reset");
    // command table in controller output mode
    foreach (rows[i]) begin
      clr();
      go(rows[i][11:4]);
      chk(flags, {4'h0, rows[i][3:0]});
    end
    $display("test done: command table");
    // peripheral input: pins follow only after reconfigure
    HOST.wr(ADDR_GCFG, 8'h03);
    #1 chk({6'h00, mode_pin, dir_pin}, 8'h00);
    go(8'h80);
    chk({4'h0, mode_pin, dir_pin, busy_oe_n, ack_oe_n}, 8'h0C);
    go(8'h24);
    chk({7'h00, busy_out}, 8'h01);
    go(8'h21);
    chk({7'h00, busy_out}, 8'h00);
    // parallel beside signal in input mode: busy must not move
    clr();
    go(8'h66);
    chk({6'h00, bz_seen, busy_out}, 8'h00);
    clr();
    go(8'h25);
    chk({6'h00, bz_seen, busy_out}, 8'h02);
    clr();
    go(8'h22);
    repeat (40) @(posedge mclk);
    chk(ak_cnt, ACK_LOW);
    // a programmed width above the default stretches the pulse
    HOST.wr(ADDR_ACK_WIDTH, 8'h07);
    clr();
    go(8'h22);
    repeat (40) @(posedge mclk);
    chk(ak_cnt, 8'(7 * UNIT));
    $display("test done: signal commands");
    // peripheral output keeps busy off; controller input drops ack
    HOST.wr(ADDR_GCFG, 8'h02);
    go(8'h80);
    go(8'h24);
    chk({7'h00, busy_out}, 8'h00);
    HOST.wr(ADDR_GCFG, 8'h01);
    go(8'h80);
    clr();
    go(8'h22);
    repeat (40) @(posedge mclk);
    chk(ak_cnt, 8'h00);
    $display("test done: mode limits");
    // clock enable low: a command write is not taken
    @(posedge mclk) ce <= 1'b0;
    HOST.wr(ADDR_CMD, 8'h41);
    @(posedge mclk) ce <= 1'b1;
    HOST.rd(ADDR_CMD, d);
    chk(d, CMD_IDLE);
    chk({7'h00, transfers_enabled}, 8'h00);
    $display("test done: clock enable");
    // software reset while the channel and timer run
    go(8'h58);
    go(8'h41);
    HOST.wr(ADDR_CMD, 8'h81);
    repeat (3) @(posedge mclk);
    #1 chk(outs, 8'h07);
    HOST.rd(ADDR_REVISION, d);
    chk(d, 8'h00);
    HOST.poll(ADDR_REVISION, REV, ok);
    chk({7'h00, ok}, 8'h01);
    if (!ok) summarize();
    HOST.rd(ADDR_GCFG, d);
    chk(d, GCFG_RST);
    $display("test done: software reset");
    summarize();
  end
endmodule : ppcd_tb_top
`default_nettype wire
